// [src/mee_defs.svh]
/*
  Constants of the local memory error handling block: widths, register
  offsets, bit positions, reset values and decode constants.
  Assumes it is included by bare name; definitions only.
*/
`ifndef MEE_DEFS_SVH
`define MEE_DEFS_SVH

// ==========================================================
// Widths
`define MEE_DW 32
`define MEE_CW 7
`define MEE_CWORD 39
`define MEE_AW 8
`define MEE_DEPTH 256
`define MEE_CNT_W 10
`define MEE_RA_W 8
`define MEE_TIDX_W 6

// ==========================================================
// Register offsets (byte addresses)
`define MEE_OFS_STATUS 8'h00
`define MEE_OFS_MASK 8'h04
`define MEE_OFS_COUNT 8'h08
`define MEE_OFS_CE_ADDR 8'h0C
`define MEE_OFS_UE_ADDR 8'h10
`define MEE_OFS_INJ_DATA 8'h14
`define MEE_OFS_INJ_CHK 8'h18
`define MEE_OFS_CORE 8'h1C

// ==========================================================
// Field positions
`define MEE_BIT_CE 0
`define MEE_BIT_UE 1
`define MEE_BIT_EE 0
`define MEE_BIT_INPROG 1
`define MEE_BIT_HALT 2
`define MEE_TRANSLATION_ENTRY_HIGH_REG_VALID_BIT 6

// ==========================================================
// Reset values and decode constants
`define MEE_RST_EE 1'b0
`define MEE_RST_MASK 2'h0
`define MEE_BTB_SYNC_OFS 32'h00000004

`endif

// [src/mee_pkg.sv]
/*
  Types of the local memory error handling block: bus requests and
  answers, maintenance operations and the state record of the top.
  Assumes mee_defs.svh is on the include path.
*/
`include "mee_defs.svh"

package mee_pkg;

  // ==========================================================
  // Local memory bus carriers
  typedef struct packed {
    logic valid;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mee_lmb_req_t;

  typedef struct packed {
    logic ready;
    logic [31:0] rdata;
    logic ce;
    logic ue;
  } mee_lmb_rsp_t;

  // ==========================================================
  // Register port carrier
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`MEE_RA_W-1:0] addr;
    logic [31:0] wdata;
  } mee_reg_req_t;

  // ==========================================================
  // Maintenance operations from the pipeline
  typedef enum logic [1:0] {
    MEE_OP_ICACHE_INV,
    MEE_OP_DCACHE_INV,
    MEE_OP_TRANSLATION_ENTRY_HIGH_REG_WR,
    MEE_OP_BRANCH_IMM
  } mee_op_t;

  typedef struct packed {
    logic valid;
    mee_op_t op;
    logic sync;
    logic [`MEE_TIDX_W-1:0] index;
    logic [31:0] operand;
  } mee_maint_req_t;

  typedef struct packed {
    logic icache_inv;
    logic dcache_inv;
    logic tlb_inv;
    logic btb_flush;
    logic [31:0] line_addr;
    logic [`MEE_TIDX_W-1:0] tlb_index;
  } mee_maint_rsp_t;

  // ==========================================================
  // Registered state of the top module, all but the memory array
  typedef struct packed {
    logic if_v;
    logic [31:0] if_a;
    logic d_v;
    logic d_we;
    logic [31:0] d_a;
    mee_lmb_rsp_t if_rsp;
    mee_lmb_rsp_t d_rsp;
    logic ibus_exc;
    logic dbus_exc;
    logic ee;
    logic in_prog;
    logic halted;
    logic fatal;
    logic ce_st;
    logic ue_st;
    logic [1:0] mask;
    logic [`MEE_CNT_W-1:0] cnt;
    logic [31:0] ce_addr;
    logic [31:0] ue_addr;
    logic [31:0] inj_d;
    logic [`MEE_CW-1:0] inj_c;
    logic irq;
    logic [31:0] rdata;
    mee_maint_rsp_t maint;
  } mee_state_t;

endpackage

// [src/mee_secded.sv]
/*
  Single error correcting, double error detecting code for one 32-bit
  word: six Hamming check bits plus an overall parity bit.
  Assumes purely combinational use; encoder and decoder share the code.
*/
`timescale 1ns/10ps
`include "mee_defs.svh"

module mee_secded
  import mee_pkg::*;
(
  input wire logic [`MEE_DW-1:0] data_in,
  input wire logic [`MEE_CW-1:0] check_in,
  output logic [`MEE_CW-1:0] enc_out,
  output logic [`MEE_DW-1:0] data_out,
  output logic ce_out,
  output logic ue_out
);

  // ==========================================================
  // Encode and decode in one pass
  always_comb begin
    logic [5:0] posn [0:`MEE_DW-1];
    logic [5:0] p;
    logic [5:0] hc;
    logic [5:0] syn;
    logic ovr;
    posn = '{default: 6'h00};
    syn = 6'h00;
    ovr = 1'b0;
    p = 6'h03;
    hc = 6'h00;
    // Data bits skip the power-of-two positions of check bits
    for (int i = 0; i < `MEE_DW; i++) begin
      posn[i] = p;
      p = p + 6'h01;
      if ((p & (p - 6'h01)) == 6'h00) begin
        p = p + 6'h01;
      end
    end
    for (int i = 0; i < `MEE_DW; i++) begin
      if (data_in[i]) begin
        hc = hc ^ posn[i];
      end
    end
    // Overall parity makes the whole codeword even
    enc_out = {(^data_in) ^ (^hc), hc};
    syn = hc ^ check_in[5:0];
    ovr = (^data_in) ^ (^check_in);
    data_out = data_in;
    // Odd parity means one flipped bit; flip back if it is a data bit
    for (int i = 0; i < `MEE_DW; i++) begin
      if (ovr && (syn == posn[i])) begin
        data_out[i] = ~data_in[i];
      end
    end
    ce_out = ovr;
    ue_out = !ovr && (syn != 6'h00);
  end

endmodule

// [src/mee_ecc_core.sv]
/*
  Protected local block memory with its error handling: fetch and data
  ports, correction, error registers, bus exceptions, fatal halt and the
  invalidation effects used by software scrubbing.
  Assumes one clock, all inputs from logic on that clock, and a register
  master that never issues read and write strobes together.
*/
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "mee_defs.svh"

// Operation
// RULE1 - Error indications driven when fault tolerant
// RULE2 - Uncorrectable error raises matching bus exception
// RULE3 - Nested bus exception halts, fatal output set
// RULE4 - Single-bit errors corrected; only uncorrectable excepts
// RULE5 - Minimal configuration has no error registers
// RULE6 - Counter counts corrected errors, ten bits
// RULE7 - Corrected error captures address, sets flag
// RULE8 - Interrupt and address read gated by options
// RULE9 - Handler reads then rewrites failing address
// RULE10 - Full adds uncorrectable address and injection
// RULE11 - Scrubber reads and rewrites every address
// RULE12 - Line invalidate instruction invalidates addressed line
// RULE13 - Cleared valid bit invalidates translation entry
// RULE14 - Synchronizing branch offset four flushes targets
// RULE15 - Halt and fatal output hold until resume
module mee_ecc_core
  import mee_pkg::*;
#(
  parameter bit FAULT_TOLERANT = 1'b1,
  parameter bit CE_COUNTER_OPTION = 1'b1,
  parameter bit ECC_STATUS_OPTION = 1'b1,
  parameter bit CE_FAILING_REGS_OPTION = 1'b1,
  parameter bit UNCORRECTABLE_FAILING_REGS_OPTION = 1'b1,
  parameter bit ERROR_INJECTION_OPTION = 1'b1
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire mee_lmb_req_t if_req_in,
  output mee_lmb_rsp_t if_rsp_out,
  input wire mee_lmb_req_t d_req_in,
  output mee_lmb_rsp_t d_rsp_out,
  input wire logic exc_return_in,
  input wire logic dbg_resume_in,
  output logic ibus_exc_out,
  output logic dbus_exc_out,
  output logic halted_out,
  output logic fatal_error_out,
  input wire mee_maint_req_t maint_in,
  output mee_maint_rsp_t maint_out,
  input wire mee_reg_req_t reg_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out
);

  // ==========================================================
  // State, memory and decoder wires
  mee_state_t st_q; // Registered state
  mee_state_t st_d; // Next state
  logic [`MEE_CWORD-1:0] mem [0:`MEE_DEPTH-1]; // Codewords, check bits on top
  logic [`MEE_CWORD-1:0] if_raw_w; // Fetch codeword
  logic [`MEE_CWORD-1:0] d_raw_w; // Data codeword
  logic [`MEE_DW-1:0] if_fix_w; // Corrected fetch word
  logic [`MEE_DW-1:0] d_fix_w; // Corrected data word
  logic if_ce_raw_w, if_ue_raw_w, d_ce_raw_w, d_ue_raw_w; // Raw decoder flags
  logic [`MEE_CW-1:0] wr_chk_w; // Check bits of write data
  logic ce_if_w; // Corrected error on fetch
  logic ue_if_w; // Uncorrectable error on fetch
  logic ce_d_w; // Corrected error on data read
  logic ue_d_w; // Uncorrectable error on data read
  logic mem_we_w; // Data write accepted
  logic cnt_wr_w; // Software writes the counter

  // Asynchronous array read of the word staged one cycle earlier
  assign if_raw_w = mem[st_q.if_a[`MEE_AW+1:2]];
  assign d_raw_w = mem[st_q.d_a[`MEE_AW+1:2]];

  // ==========================================================
  // Codecs: fetch check, data check, write encode
  mee_secded u_if_dec (
    .data_in(if_raw_w[`MEE_DW-1:0]), .check_in(if_raw_w[`MEE_CWORD-1:`MEE_DW]),
    .enc_out(), .data_out(if_fix_w), .ce_out(if_ce_raw_w), .ue_out(if_ue_raw_w)
  );

  mee_secded u_d_dec (
    .data_in(d_raw_w[`MEE_DW-1:0]), .check_in(d_raw_w[`MEE_CWORD-1:`MEE_DW]),
    .enc_out(), .data_out(d_fix_w), .ce_out(d_ce_raw_w), .ue_out(d_ue_raw_w)
  );

  mee_secded u_wr_enc (
    .data_in(d_req_in.wdata), .check_in('0),
    .enc_out(wr_chk_w), .data_out(), .ce_out(), .ue_out()
  );

  // ==========================================================
  // Error events
  // RULE1 indications when fault tolerant
  assign ce_if_w = FAULT_TOLERANT && st_q.if_v && if_ce_raw_w;
  assign ue_if_w = FAULT_TOLERANT && st_q.if_v && if_ue_raw_w;
  assign ce_d_w = FAULT_TOLERANT && st_q.d_v && !st_q.d_we && d_ce_raw_w;
  assign ue_d_w = FAULT_TOLERANT && st_q.d_v && !st_q.d_we && d_ue_raw_w;
  assign mem_we_w = nrst_in && d_req_in.valid && d_req_in.we && !st_q.halted;
  assign cnt_wr_w = CE_COUNTER_OPTION && reg_in.wr && (reg_in.addr == `MEE_OFS_COUNT);

  // ==========================================================
  // Memory write with optional fault injection
  // RULE11 rewrite stores corrected code
  always_ff @(posedge clk_in) begin
    if (mem_we_w) begin
      mem[d_req_in.addr[`MEE_AW+1:2]] <= {wr_chk_w ^ st_q.inj_c, d_req_in.wdata ^ st_q.inj_d};
    end
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [`MEE_CNT_W:0] sum; // Counter plus events, one spare bit
    logic [`MEE_CNT_W-1:0] base; // Counter after a software write
    st_d = st_q;
    sum = '0;
    base = st_q.cnt;
    // Stage the address; a halted core takes no access
    st_d.if_v = if_req_in.valid && !st_q.halted;
    st_d.if_a = if_req_in.addr;
    st_d.d_v = d_req_in.valid && !st_q.halted;
    st_d.d_we = d_req_in.we;
    st_d.d_a = d_req_in.addr;
    // RULE4 return corrected words
    st_d.if_rsp.ready = st_q.if_v;
    st_d.if_rsp.rdata = !st_q.if_v ? '0 : (FAULT_TOLERANT ? if_fix_w : if_raw_w[`MEE_DW-1:0]);
    st_d.if_rsp.ce = ce_if_w;
    st_d.if_rsp.ue = ue_if_w;
    st_d.d_rsp.ready = st_q.d_v;
    st_d.d_rsp.ce = ce_d_w;
    st_d.d_rsp.ue = ue_d_w;
    // Writes and idle cycles answer zero, so unwritten words never leak out
    st_d.d_rsp.rdata = (st_q.d_we || !st_q.d_v) ? '0
      : (FAULT_TOLERANT ? d_fix_w : d_raw_w[`MEE_DW-1:0]);
    // Exception entry and exit
    st_d.ibus_exc = 1'b0;
    st_d.dbus_exc = 1'b0;
    if (exc_return_in) begin
      st_d.in_prog = 1'b0;
    end
    // RULE15 only resume releases halt
    if (st_q.halted && dbg_resume_in) begin
      st_d.halted = 1'b0;
      st_d.fatal = 1'b0;
      st_d.in_prog = 1'b0;
    end
    // Software side of the machine status bits
    if (reg_in.wr && (reg_in.addr == `MEE_OFS_CORE)) begin
      st_d.ee = reg_in.wdata[`MEE_BIT_EE];
      if (reg_in.wdata[`MEE_BIT_INPROG]) begin
        st_d.in_prog = 1'b0;
      end
    end
    if (ue_if_w || ue_d_w) begin
      if (st_q.in_prog) begin
        // RULE3 nested exception halts core
        st_d.halted = 1'b1;
        st_d.fatal = 1'b1;
      end else if (st_q.ee) begin
        // RULE2 exception on arriving side
        st_d.dbus_exc = ue_d_w;
        st_d.ibus_exc = !ue_d_w;
        st_d.in_prog = 1'b1;
      end
    end
    // Status clear by writing ones; new events win
    if (ECC_STATUS_OPTION && reg_in.wr && (reg_in.addr == `MEE_OFS_STATUS)) begin
      st_d.ce_st = st_q.ce_st && !reg_in.wdata[`MEE_BIT_CE];
      st_d.ue_st = st_q.ue_st && !reg_in.wdata[`MEE_BIT_UE];
    end
    if (ECC_STATUS_OPTION && reg_in.wr && (reg_in.addr == `MEE_OFS_MASK)) begin
      st_d.mask = reg_in.wdata[1:0];
    end
    // RULE7 flag and first address
    if ((ce_if_w || ce_d_w) && !st_q.ce_st) begin
      st_d.ce_addr = ce_d_w ? st_q.d_a : st_q.if_a;
    end
    if (ce_if_w || ce_d_w) begin
      st_d.ce_st = 1'b1;
    end
    // RULE10 uncorrectable first address
    if ((ue_if_w || ue_d_w) && !st_q.ue_st) begin
      st_d.ue_addr = ue_d_w ? st_q.d_a : st_q.if_a;
    end
    if (ue_if_w || ue_d_w) begin
      st_d.ue_st = 1'b1;
    end
    // RULE6 saturating corrected error count
    if (cnt_wr_w) begin
      base = reg_in.wdata[`MEE_CNT_W-1:0];
    end
    sum = {1'b0, base} + {{`MEE_CNT_W{1'b0}}, ce_if_w} + {{`MEE_CNT_W{1'b0}}, ce_d_w};
    if (CE_COUNTER_OPTION) begin
      st_d.cnt = sum[`MEE_CNT_W] ? '1 : sum[`MEE_CNT_W-1:0];
    end
    // RULE10 injection masks, used once
    if (ERROR_INJECTION_OPTION) begin
      if (mem_we_w) begin
        st_d.inj_d = '0;
        st_d.inj_c = '0;
      end
      if (reg_in.wr && (reg_in.addr == `MEE_OFS_INJ_DATA)) begin
        st_d.inj_d = reg_in.wdata;
      end
      if (reg_in.wr && (reg_in.addr == `MEE_OFS_INJ_CHK)) begin
        st_d.inj_c = reg_in.wdata[`MEE_CW-1:0];
      end
    end
    // RULE8 interrupt only with status option
    st_d.irq = ECC_STATUS_OPTION && ((st_q.ce_st && st_q.mask[`MEE_BIT_CE])
      || (st_q.ue_st && st_q.mask[`MEE_BIT_UE]));
    // Register read, data valid in the next cycle only
    st_d.rdata = '0;
    if (reg_in.rd) begin
      // RULE5 absent registers read zero
      unique case (reg_in.addr)
        `MEE_OFS_STATUS: st_d.rdata = ECC_STATUS_OPTION ? {30'h0, st_q.ue_st, st_q.ce_st} : '0;
        `MEE_OFS_MASK: st_d.rdata = ECC_STATUS_OPTION ? {30'h0, st_q.mask} : '0;
        `MEE_OFS_COUNT: st_d.rdata = CE_COUNTER_OPTION ? {22'h0, st_q.cnt} : '0;
        // RULE8 address readable with option
        `MEE_OFS_CE_ADDR: st_d.rdata = CE_FAILING_REGS_OPTION ? st_q.ce_addr : '0;
        `MEE_OFS_UE_ADDR: st_d.rdata = UNCORRECTABLE_FAILING_REGS_OPTION ? st_q.ue_addr : '0;
        `MEE_OFS_INJ_DATA: st_d.rdata = ERROR_INJECTION_OPTION ? st_q.inj_d : '0;
        `MEE_OFS_INJ_CHK: st_d.rdata = ERROR_INJECTION_OPTION ? {25'h0, st_q.inj_c} : '0;
        `MEE_OFS_CORE: st_d.rdata = {29'h0, st_q.halted, st_q.in_prog, st_q.ee};
        default: st_d.rdata = '0;
      endcase
    end
    // Maintenance effects, one-cycle pulses
    st_d.maint = '0;
    if (maint_in.valid && !st_q.halted) begin
      unique case (maint_in.op)
        MEE_OP_ICACHE_INV: begin
          // RULE12 instruction line invalidate
          st_d.maint.icache_inv = 1'b1;
          st_d.maint.line_addr = maint_in.operand;
        end
        MEE_OP_DCACHE_INV: begin
          // RULE12 data line invalidate
          st_d.maint.dcache_inv = 1'b1;
          st_d.maint.line_addr = maint_in.operand;
        end
        MEE_OP_TRANSLATION_ENTRY_HIGH_REG_WR: begin
          // RULE13 cleared valid drops entry
          st_d.maint.tlb_inv = !maint_in.operand[`MEE_TRANSLATION_ENTRY_HIGH_REG_VALID_BIT];
          st_d.maint.tlb_index = maint_in.index;
        end
        MEE_OP_BRANCH_IMM: begin
          // RULE14 sync branch offset four
          st_d.maint.btb_flush = maint_in.sync && (maint_in.operand == `MEE_BTB_SYNC_OFS);
        end
      endcase
    end
  end

  // ==========================================================
  // State register, synchronous reset
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_q <= '0;
      st_q.ee <= `MEE_RST_EE;
      st_q.mask <= `MEE_RST_MASK;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign if_rsp_out = st_q.if_rsp;
  assign d_rsp_out = st_q.d_rsp;
  assign ibus_exc_out = st_q.ibus_exc;
  assign dbus_exc_out = st_q.dbus_exc;
  assign halted_out = st_q.halted;
  assign fatal_error_out = st_q.fatal;
  assign maint_out = st_q.maint;
  assign reg_rdata_out = st_q.rdata;
  assign irq_out = st_q.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  // RULE2 fetch exception cause
  ibus_exc_a: assert property ( // RULE2
    ibus_exc_out |-> if_rsp_out.ue && $past(st_q.ee) && !$past(st_q.in_prog))
    else $error("fetch exception without uncorrectable fetch");
  // RULE2 data exception raised
  dbus_raise_a: assert property ( // RULE2
    (ue_d_w && st_q.ee && !st_q.in_prog) |=> dbus_exc_out && d_rsp_out.ue)
    else $error("data exception missing");
  // RULE3 nested exception halts
  nested_halt_a: assert property ( // RULE3
    ((ue_if_w || ue_d_w) && st_q.in_prog) |=> fatal_error_out && halted_out)
    else $error("nested bus exception did not halt");
  // RULE15 fatal output holds
  fatal_hold_a: assert property ( // RULE15
    (fatal_error_out && !dbg_resume_in) |=> fatal_error_out)
    else $error("fatal output dropped without resume");
  // RULE15 no fetch while halted
  halt_fetch_a: assert property ( // RULE15
    halted_out [*2] |=> !if_rsp_out.ready)
    else $error("fetch answered while halted");
  // RULE4 corrected not flagged uncorrectable, no exception
  ce_only_a: assert property ( // RULE4
    d_rsp_out.ce |-> !d_rsp_out.ue && !dbus_exc_out)
    else $error("corrected error raised exception");
  // RULE6 counter advances
  ce_count_a: assert property ( // RULE6
    (CE_COUNTER_OPTION && (ce_if_w || ce_d_w) && (st_q.cnt != '1) && !cnt_wr_w)
      |=> st_q.cnt > $past(st_q.cnt))
    else $error("corrected error not counted");
  // RULE7 first address captured
  ce_addr_a: assert property ( // RULE7
    (ce_d_w && !st_q.ce_st) |=> st_q.ce_st && (st_q.ce_addr == $past(st_q.d_a)))
    else $error("failing address not captured");
  // RULE8 interrupt gating
  irq_gate_a: assert property ( // RULE8
    irq_out |-> ECC_STATUS_OPTION && ($past(st_q.ce_st) || $past(st_q.ue_st)))
    else $error("interrupt without enabled status");
  // RULE13 translation entry drop
  tlb_inv_a: assert property ( // RULE13
    (maint_in.valid && (maint_in.op == MEE_OP_TRANSLATION_ENTRY_HIGH_REG_WR) && !st_q.halted
      && !maint_in.operand[`MEE_TRANSLATION_ENTRY_HIGH_REG_VALID_BIT]) |=> maint_out.tlb_inv)
    else $error("translation entry not invalidated");
  // RULE14 branch target flush
  btb_flush_a: assert property ( // RULE14
    (maint_in.valid && (maint_in.op == MEE_OP_BRANCH_IMM) && maint_in.sync
      && (maint_in.operand == `MEE_BTB_SYNC_OFS) && !st_q.halted) |=> maint_out.btb_flush)
    else $error("branch target flush missing");

endmodule

// [verif/mee_core_model.sv]
/*
  Behavioural processor core on the fetch and data ports.
  Assumes answers come two cycles after the request cycle.
*/
`timescale 1ns/10ps

module mee_core_model
  import mee_pkg::*;
(
  input wire logic clk_in,
  output mee_lmb_req_t if_req_out,
  output mee_lmb_req_t d_req_out,
  input wire mee_lmb_rsp_t if_rsp_in,
  input wire mee_lmb_rsp_t d_rsp_in
);
  // ==========================================================
  // Idle ports
  initial begin
    if_req_out = '0;
    d_req_out = '0;
  end

  // ==========================================================
  // One access; answer taken in its third cycle
  task automatic access(input bit fetch, input bit we, input logic [31:0] a,
      input logic [31:0] wd, output mee_lmb_rsp_t rsp);
    mee_lmb_req_t r;
    r = '{valid: 1'b1, we: we, addr: a, wdata: wd};
    @(posedge clk_in);
    if_req_out <= fetch ? r : if_req_out;
    d_req_out <= fetch ? d_req_out : r;
    @(posedge clk_in);
    // Released lines show the inverse, not a stale copy
    r = '{valid: 1'b0, we: 1'b0, addr: ~a, wdata: ~wd};
    if_req_out <= fetch ? r : if_req_out;
    d_req_out <= fetch ? d_req_out : r;
    @(posedge clk_in);
    #1;
    rsp = fetch ? if_rsp_in : d_rsp_in;
  endtask

  // ==========================================================
  // read then rewrite
  task automatic scrub(input logic [31:0] a);
    mee_lmb_rsp_t rsp;
    access(1'b0, 1'b0, a, 32'h0, rsp);
    access(1'b0, 1'b1, a, rsp.rdata, rsp);
  endtask
endmodule

// [verif/test_mee_ecc_core.sv]
/*
  Self-checking bench of the local memory error handling block.
  Assumes the full option set on the main instance, none on the second.
*/
`timescale 1ns/10ps
`include "mee_defs.svh"

module test_mee_ecc_core
  import mee_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  logic clk_in, nrst_in, exc_return_in, dbg_resume_in;
  mee_lmb_req_t if_req, d_req;
  mee_lmb_rsp_t if_rsp, d_rsp, d_rsp_min;
  logic ibus_exc, dbus_exc, halted, fatal, irq, fatal_min, irq_min;
  mee_maint_req_t maint;
  mee_maint_rsp_t mrsp;
  mee_reg_req_t rq;
  logic [31:0] rdata, rdata_min, rd_min;
  int mismatches, samples_checked, cycles;

  // ==========================================================
  // Design, partner and a minimal second instance
  mee_ecc_core mee_ecc_core_inst (.clk_in(clk_in), .nrst_in(nrst_in), .if_req_in(if_req),
    .if_rsp_out(if_rsp), .d_req_in(d_req), .d_rsp_out(d_rsp), .exc_return_in(exc_return_in),
    .dbg_resume_in(dbg_resume_in), .ibus_exc_out(ibus_exc), .dbus_exc_out(dbus_exc),
    .halted_out(halted), .fatal_error_out(fatal), .maint_in(maint), .maint_out(mrsp),
    .reg_in(rq), .reg_rdata_out(rdata), .irq_out(irq));
  mee_ecc_core #(.CE_COUNTER_OPTION(1'b0), .ECC_STATUS_OPTION(1'b0),
    .CE_FAILING_REGS_OPTION(1'b0), .UNCORRECTABLE_FAILING_REGS_OPTION(1'b0),
    .ERROR_INJECTION_OPTION(1'b0)) mee_ecc_core_min_inst (.clk_in(clk_in),
    .nrst_in(nrst_in), .if_req_in(if_req), .if_rsp_out(), .d_req_in(d_req),
    .d_rsp_out(d_rsp_min), .exc_return_in(exc_return_in), .dbg_resume_in(dbg_resume_in),
    .ibus_exc_out(), .dbus_exc_out(), .halted_out(), .fatal_error_out(fatal_min),
    .maint_in(maint), .maint_out(), .reg_in(rq), .reg_rdata_out(rdata_min), .irq_out(irq_min));
  mee_core_model mee_core_model_inst (.clk_in(clk_in), .if_req_out(if_req),
    .d_req_out(d_req), .if_rsp_in(if_rsp), .d_rsp_in(d_rsp));

  // ==========================================================
  // Clock, 25 ns period
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // Hang guard, far above the run length
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end

  // ==========================================================
  // Shared helpers
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    rq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    rq <= '0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    rq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_in);
    rq <= '0;
    #1;
    d = rdata;
    rd_min = rdata_min;
  endtask

  task automatic pulse(input bit resume);
    @(posedge clk_in);
    dbg_resume_in <= resume;
    exc_return_in <= !resume;
    @(posedge clk_in);
    dbg_resume_in <= 1'b0;
    exc_return_in <= 1'b0;
  endtask

  task automatic mop(input mee_op_t op, input logic s, input logic [31:0] opd,
      input logic [3:0] e);
    @(posedge clk_in);
    maint <= '{valid: 1'b1, op: op, sync: s, index: 6'h2A, operand: opd};
    @(posedge clk_in);
    maint <= '0;
    #1;
    chk("maint", {mrsp.icache_inv, mrsp.dcache_inv, mrsp.tlb_inv, mrsp.btb_flush}, e);
    if (e[3] | e[2]) chk("line", mrsp.line_addr, opd);
    if (e[1]) chk("tlb_idx", mrsp.tlb_index, 6'h2A);
  endtask

  // ==========================================================
  // Corrected error: data, counter, address, interrupt, scrub
  task automatic t_ce();
    mee_lmb_rsp_t r;
    logic [31:0] v;
    reg_wr(`MEE_OFS_INJ_DATA, 32'h00000001);
    mee_core_model_inst.access(1'b0, 1'b1, 32'h10, 32'hA5A50F0F, r);
    mee_core_model_inst.access(1'b0, 1'b0, 32'h10, 32'h0, r);
    chk("ce_data", r.rdata, 32'hA5A50F0F);
    chk("ce_flags", {r.ready, r.ce, r.ue, dbus_exc}, 4'hC);
    chk("min_data", d_rsp_min.rdata, 32'hA5A50F0F);
    chk("min_flags", {d_rsp_min.ready, d_rsp_min.ce}, 2'b10);
    reg_rd(`MEE_OFS_STATUS, v);
    chk("status", v, 32'h1);
    reg_rd(`MEE_OFS_COUNT, v);
    chk("count", v, 32'h1);
    chk("min_count", rd_min, 32'h0);
    reg_rd(`MEE_OFS_CE_ADDR, v);
    chk("ce_addr", v, 32'h10);
    chk("irq_masked", irq, 1'b0);
    reg_wr(`MEE_OFS_MASK, 32'h1);
    repeat (2) @(posedge clk_in);
    #1;
    chk("irq", irq, 1'b1);
    chk("min_irq", irq_min, 1'b0);
    mee_core_model_inst.scrub(32'h10);
    mee_core_model_inst.access(1'b0, 1'b0, 32'h10, 32'h0, r);
    chk("scrubbed", r.rdata, 32'hA5A50F0F);
    chk("scrub_ce", {r.ready, r.ce}, 2'b10);
    reg_wr(`MEE_OFS_STATUS, 32'h1);
    repeat (2) @(posedge clk_in);
    #1;
    chk("irq_clr", irq, 1'b0);
    reg_wr(`MEE_OFS_COUNT, 32'hFFFFFFFF);
    reg_rd(`MEE_OFS_COUNT, v);
    chk("count_w", v, 32'h3FF);
    reg_wr(`MEE_OFS_INJ_CHK, 32'h00000040);
    mee_core_model_inst.access(1'b0, 1'b1, 32'h10, 32'h5A5A0000, r);
    mee_core_model_inst.access(1'b0, 1'b0, 32'h10, 32'h0, r);
    chk("chk_flip", {r.ce, r.ue}, 2'b10);
    chk("chk_data", r.rdata, 32'h5A5A0000);
  endtask

  // ==========================================================
  // Uncorrectable errors, exceptions and nested halt
  task automatic t_ue();
    mee_lmb_rsp_t r;
    logic [31:0] v;
    reg_wr(`MEE_OFS_INJ_DATA, 32'h00000003);
    mee_core_model_inst.access(1'b0, 1'b1, 32'h20, 32'h12345678, r);
    mee_core_model_inst.access(1'b0, 1'b0, 32'h20, 32'h0, r);
    chk("ue_no_ee", {r.ue, dbus_exc, ibus_exc}, 3'b100);
    reg_rd(`MEE_OFS_UE_ADDR, v);
    chk("ue_addr", v, 32'h20);
    reg_wr(`MEE_OFS_CORE, 32'h1);
    mee_core_model_inst.access(1'b0, 1'b0, 32'h20, 32'h0, r);
    chk("ue_data", {r.ue, dbus_exc, ibus_exc}, 3'b110);
    reg_rd(`MEE_OFS_CORE, v);
    chk("in_prog", v, 32'h3);
    pulse(1'b0);
    mee_core_model_inst.access(1'b1, 1'b0, 32'h20, 32'h0, r);
    chk("ue_fetch", {r.ue, ibus_exc, dbus_exc}, 3'b110);
    chk("no_halt", {halted, fatal}, 2'b00);
    mee_core_model_inst.access(1'b1, 1'b0, 32'h20, 32'h0, r);
    @(posedge clk_in);
    #1;
    chk("nested", {halted, fatal}, 2'b11);
    chk("min_fatal", fatal_min, 1'b0);
    repeat (6) @(posedge clk_in);
    mee_core_model_inst.access(1'b1, 1'b0, 32'h10, 32'h0, r);
    chk("dropped", {r.ready, halted, fatal}, 3'b011);
    mop(MEE_OP_BRANCH_IMM, 1'b1, 32'h4, 4'h0);
    pulse(1'b1);
    @(posedge clk_in);
    #1;
    chk("resumed", {halted, fatal}, 2'b00);
  endtask

  // ==========================================================
  // Every maintenance operation taken; translation entry and branch also refused
  task automatic t_maint();
    mop(MEE_OP_ICACHE_INV, 1'b0, 32'h40, 4'h8);
    mop(MEE_OP_DCACHE_INV, 1'b0, 32'h40, 4'h4);
    mop(MEE_OP_TRANSLATION_ENTRY_HIGH_REG_WR, 1'b0, 32'h0, 4'h2);
    mop(MEE_OP_TRANSLATION_ENTRY_HIGH_REG_WR, 1'b0, 32'h40, 4'h0);
    mop(MEE_OP_BRANCH_IMM, 1'b1, 32'h4, 4'h1);
    mop(MEE_OP_BRANCH_IMM, 1'b1, 32'h8, 4'h0);
    mop(MEE_OP_BRANCH_IMM, 1'b0, 32'h4, 4'h0);
  endtask

  // ==========================================================
  // Verdict and end of run
  task automatic summarize();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence after a six cycle reset
  initial begin
    nrst_in = 1'b0;
    exc_return_in = 1'b0;
    dbg_resume_in = 1'b0;
    maint = '0;
    rq = '0;
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_ce();
    t_ue();
    t_maint();
    summarize();
  end
endmodule
